/* ppom_cfg.svh */
// Constants of the port pin override mux: widths, register offsets, field positions and reset values.
// Assumes it is included by bare name from the package and the design modules.
`ifndef PPOM_CFG_SVH
`define PPOM_CFG_SVH

`define PPOM_PINS         8
`define PPOM_ADR_W        8
`define PPOM_DAT_W        32
`define PPOM_SENSE_W      16

`define PPOM_OFS_OUT      8'h00
`define PPOM_OFS_DIR      8'h04
`define PPOM_OFS_PIN      8'h08
`define PPOM_OFS_CTRL     8'h0c
`define PPOM_OFS_STAT     8'h10
`define PPOM_OFS_MASK     8'h14
`define PPOM_OFS_SENSE    8'h18

`define PPOM_CTRL_PUD_BIT 0

`define PPOM_RST_BYTE     8'h00
`define PPOM_RST_SENSE    16'h0000
`define PPOM_RST_WORD     32'h0000_0000

`endif

/* ppom_pkg.sv */
// Types of the port pin override mux: sleep states, edge sense modes and module state records.
// Assumes ppom_cfg.svh is on the include path.
`include "ppom_cfg.svh"

package ppom_pkg;

  typedef enum logic [5:0] {
    PPOM_SLP_ACTIVE  = 6'h01,
    PPOM_SLP_IDLE    = 6'h02,
    PPOM_SLP_ADC_NR  = 6'h04,
    PPOM_SLP_PDOWN   = 6'h08,
    PPOM_SLP_PSAVE   = 6'h10,
    PPOM_SLP_STANDBY = 6'h20
  } ppom_sleep_type;

  typedef enum logic [1:0] {
    PPOM_SENSE_LOW  = 2'h0,
    PPOM_SENSE_ANY  = 2'h1,
    PPOM_SENSE_FALL = 2'h2,
    PPOM_SENSE_RISE = 2'h3
  } ppom_sense_type;

  typedef struct packed {
    logic                      sync_first;
    logic                      sync_second;
  } ppom_pin_state_type;

  typedef struct packed {
    logic [`PPOM_PINS-1:0]     out_data;
    logic [`PPOM_PINS-1:0]     dir;
    logic [`PPOM_PINS-1:0]     int_status;
    logic [`PPOM_PINS-1:0]     int_mask;
    logic [`PPOM_SENSE_W-1:0]  sense;
    logic                      global_pullup_disable;
    logic [`PPOM_PINS-1:0]     pin_prev;
    logic                      ack;
    logic [`PPOM_DAT_W-1:0]    rdat;
  } ppom_state_type;

endpackage : ppom_pkg

/* ppom_pin.sv */
// One pin of the port: override muxing of pull-up, driver, value and input enable, plus input synchroniser.
// Assumes a reset already synchronised to clk_i and register bits from the same clock domain.
`timescale 1ns/1ps

module ppom_pin (
  input  wire logic clk_i,                // I/O clock
  input  wire logic rst_n_i,              // Synchronised reset, active low
  input  wire logic pad_in_i,             // Raw pad level, asynchronous
  input  wire logic out_data_i,           // Output-data bit
  input  wire logic dir_i,                // Direction bit, one is output
  input  wire logic pud_i,                // Global pull-up disable
  input  wire logic clamp_i,              // Global sleep input clamp
  input  wire logic clamp_bypass_i,       // External interrupt request enabled
  input  wire logic pullup_override_en,   // Pull-up override enable
  input  wire logic pullup_override_val,  // Pull-up override value
  input  wire logic dir_override_en,      // Direction override enable
  input  wire logic dir_override_val,     // Direction override value
  input  wire logic outval_override_en,   // Output value override enable
  input  wire logic outval_override_val,  // Output value override value
  input  wire logic inen_override_en,     // Input enable override enable
  input  wire logic inen_override_val,    // Input enable override value
  output logic      pad_out_o,            // Driven pad value
  output logic      pad_oe_o,             // Pad driver enable
  output logic      pad_pullup_o,         // Pad pull-up enable
  output logic      raw_digital_in_o,     // Trigger output, not synchronised
  output logic      pin_sync_o            // Synchronised pin level
);
  import ppom_pkg::*;

  ppom_pin_state_type s;
  ppom_pin_state_type next_s;
  logic               in_enable;
  logic               trig;

  always_comb begin
    pad_pullup_o = pullup_override_en ? pullup_override_val           // RULE6
                                      : (~dir_i & out_data_i & ~pud_i); // RULE5 RULE18 RULE19
    pad_oe_o     = dir_override_en ? dir_override_val : dir_i;        // RULE7 RULE16
    pad_out_o    = pad_oe_o & (outval_override_en ? outval_override_val : out_data_i); // RULE8
    in_enable    = inen_override_en ? inen_override_val               // RULE10 RULE3
                                    : ~(clamp_i & ~clamp_bypass_i);   // RULE1 RULE2
    trig         = pad_in_i & in_enable;
    raw_digital_in_o = trig;                                          // RULE11
    next_s             = s;
    next_s.sync_first  = trig;
    next_s.sync_second = s.sync_first;
    pin_sync_o         = s.sync_second;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : ppom_pin

/* ppom_port.sv */
// Top of the port pin override mux: one port of pins with Wishbone registers and pin interrupts.
// Assumes override signals come from peripheral modules on clk_i and the pad levels are asynchronous.
//
// How it works
// RULE1 - Sleep states PDOWN, PSAVE and STANDBY clamp every digital input low.
// RULE2 - Enabled interrupt request bypasses the clamp.
// RULE3 - Input-enable override also bypasses the clamp.
// RULE4 - Clamp release edge sets the interrupt flag.
// RULE5 - Default pull-up only for input, data one.
// RULE6 - Pull-up override value decides when enabled.
// RULE7 - Direction override decides driver enable.
// RULE8 - Value override decides the driven level.
// RULE9 - Toggle override inverts the output-data bit.
// RULE10 - Input enable override decides input enable.
// RULE11 - Raw input taken before the synchroniser.
// RULE12 - Peripherals synchronise raw input themselves.
// RULE13 - Analogue path wired straight to pad.
// RULE14 - Strobes per port, overrides per pin.
// RULE15 - Peripherals generate their own override signals.
// RULE16 - Direction one output, zero input.
// RULE17 - Writing one to input bit toggles data.
// RULE18 - Global pull-up disable kills default pull-ups.
// RULE19 - No overrides gives plain I/O behaviour.
//
// Added by the designer: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`include "ppom_cfg.svh"

module ppom_port (
  input  wire logic                          clk_i,                // I/O clock, 100 MHz
  input  wire logic                          nrst_i,               // Asynchronous reset, active low
  input  wire logic                          wb_cyc_i,             // Wishbone cycle
  input  wire logic                          wb_stb_i,             // Wishbone strobe
  input  wire logic                          wb_we_i,              // Wishbone write enable
  input  wire logic [`PPOM_ADR_W-1:0]        wb_adr_i,             // Wishbone byte address
  input  wire logic [3:0]                    wb_sel_i,             // Wishbone byte selects
  input  wire logic [`PPOM_DAT_W-1:0]        wb_dat_i,             // Wishbone write data
  output logic [`PPOM_DAT_W-1:0]             wb_dat_o,             // Wishbone read data
  output logic                               wb_ack_o,             // Wishbone acknowledge
  input  wire ppom_pkg::ppom_sleep_type      sleep_mode_i,         // Sleep controller state
  input  wire logic [`PPOM_PINS-1:0]         pad_in_i,             // Pad levels, asynchronous
  output logic [`PPOM_PINS-1:0]              pad_out_o,            // Pad drive values
  output logic [`PPOM_PINS-1:0]              pad_oe_o,             // Pad driver enables
  output logic [`PPOM_PINS-1:0]              pad_pullup_o,         // Pad pull-up enables
  input  wire logic [`PPOM_PINS-1:0]         pullup_override_en,   // Per pin pull-up override enable
  input  wire logic [`PPOM_PINS-1:0]         pullup_override_val,  // Per pin pull-up override value
  input  wire logic [`PPOM_PINS-1:0]         dir_override_en,      // Per pin direction override enable
  input  wire logic [`PPOM_PINS-1:0]         dir_override_val,     // Per pin direction override value
  input  wire logic [`PPOM_PINS-1:0]         outval_override_en,   // Per pin value override enable
  input  wire logic [`PPOM_PINS-1:0]         outval_override_val,  // Per pin value override value
  input  wire logic [`PPOM_PINS-1:0]         toggle_override_en,   // Per pin toggle override enable
  input  wire logic [`PPOM_PINS-1:0]         inen_override_en,     // Per pin input enable override enable
  input  wire logic [`PPOM_PINS-1:0]         inen_override_val,    // Per pin input enable override value
  output logic [`PPOM_PINS-1:0]              raw_digital_in,       // Unsynchronised inputs to peripherals
  output logic [`PPOM_PINS-1:0]              analog_pad_path_o,    // Analogue pad level to peripherals
  input  wire logic [`PPOM_PINS-1:0]         analog_pad_path_i,    // Analogue level from peripherals
  input  wire logic [`PPOM_PINS-1:0]         analog_pad_path_oe_i, // Peripheral drives analogue pad
  input  wire logic [`PPOM_PINS-1:0]         pad_analog_i,         // Analogue pad level in
  output logic [`PPOM_PINS-1:0]              pad_analog_o,         // Analogue level to pad
  output logic [`PPOM_PINS-1:0]              pad_analog_oe_o,      // Analogue pad drive enable
  output logic                               irq_o                 // Level interrupt
);
  import ppom_pkg::*;

  // ---------------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------------

  logic [1:0] rst_sync;
  logic       rst_n;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_n = rst_sync[1];

  // ---------------------------------------------------------------------------
  // Sleep clamp
  // ---------------------------------------------------------------------------

  logic clamp;

  always_comb begin
    case (sleep_mode_i)
      PPOM_SLP_PDOWN,
      PPOM_SLP_PSAVE,
      PPOM_SLP_STANDBY: begin
        clamp = 1'b1; // RULE1
      end
      default: begin
        clamp = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Pins
  // ---------------------------------------------------------------------------

  ppom_state_type        s;
  ppom_state_type        next_s;
  logic [`PPOM_PINS-1:0] pin_sync;

  // The clock, clamp and pull-up disable fan out to every pin, overrides stay per pin.
  genvar g;
  generate
    for (g = 0; g < `PPOM_PINS; g = g + 1) begin : gen_pin
      ppom_pin u_pin (
        .clk_i               (clk_i),
        .rst_n_i             (rst_n),
        .pad_in_i            (pad_in_i[g]),
        .out_data_i          (s.out_data[g]),
        .dir_i               (s.dir[g]),
        .pud_i               (s.global_pullup_disable),                    // RULE14
        .clamp_i             (clamp),                    // RULE14
        .clamp_bypass_i      (s.int_mask[g]),            // RULE2
        .pullup_override_en  (pullup_override_en[g]),
        .pullup_override_val (pullup_override_val[g]),
        .dir_override_en     (dir_override_en[g]),
        .dir_override_val    (dir_override_val[g]),
        .outval_override_en  (outval_override_en[g]),
        .outval_override_val (outval_override_val[g]),
        .inen_override_en    (inen_override_en[g]),
        .inen_override_val   (inen_override_val[g]),
        .pad_out_o           (pad_out_o[g]),
        .pad_oe_o            (pad_oe_o[g]),
        .pad_pullup_o        (pad_pullup_o[g]),
        .raw_digital_in_o    (raw_digital_in[g]),        // RULE11
        .pin_sync_o          (pin_sync[g])
      );
    end
  endgenerate

  // The analogue path bypasses all digital logic in both directions.
  assign analog_pad_path_o = pad_analog_i;               // RULE13
  assign pad_analog_o      = analog_pad_path_i;          // RULE13
  assign pad_analog_oe_o   = analog_pad_path_oe_i;       // RULE13

  // ---------------------------------------------------------------------------
  // Register bus and state
  // ---------------------------------------------------------------------------

  logic                  req;
  logic                  wr;
  logic                  hit_out;
  logic                  hit_dir;
  logic                  hit_pin;
  logic                  hit_ctrl;
  logic                  hit_stat;
  logic                  hit_mask;
  logic                  hit_sense;
  logic [`PPOM_PINS-1:0] wbyte;
  logic [`PPOM_PINS-1:0] data_base;
  logic [`PPOM_PINS-1:0] edge_set;
  logic [`PPOM_PINS-1:0] stat_clr;
  logic [1:0]            mode;
  integer                i;

  always_comb begin
    next_s    = s;
    req       = wb_cyc_i & wb_stb_i & ~s.ack;
    wr        = wb_cyc_i & wb_stb_i & wb_we_i & s.ack; // Writes land at the acknowledging edge.
    wbyte     = wb_dat_i[`PPOM_PINS-1:0];
    hit_out   = (wb_adr_i == `PPOM_OFS_OUT);
    hit_dir   = (wb_adr_i == `PPOM_OFS_DIR);
    hit_pin   = (wb_adr_i == `PPOM_OFS_PIN);
    hit_ctrl  = (wb_adr_i == `PPOM_OFS_CTRL);
    hit_stat  = (wb_adr_i == `PPOM_OFS_STAT);
    hit_mask  = (wb_adr_i == `PPOM_OFS_MASK);
    hit_sense = (wb_adr_i == `PPOM_OFS_SENSE);
    next_s.ack = req;

    // Output data: a register write, then a software toggle, then a peripheral toggle.
    data_base = s.out_data;
    if (wr && hit_out && wb_sel_i[0]) begin
      data_base = wbyte;
    end
    if (wr && hit_pin && wb_sel_i[0]) begin
      data_base = data_base ^ wbyte;                     // RULE17
    end
    next_s.out_data = data_base ^ toggle_override_en;    // RULE9

    if (wr && hit_dir && wb_sel_i[0]) begin
      next_s.dir = wbyte;                                // RULE16
    end
    if (wr && hit_ctrl && wb_sel_i[0]) begin
      next_s.global_pullup_disable = wb_dat_i[`PPOM_CTRL_PUD_BIT];         // RULE18
    end
    if (wr && hit_mask && wb_sel_i[0]) begin
      next_s.int_mask = wbyte;
    end
    if (wr && hit_sense) begin
      if (wb_sel_i[0]) begin
        next_s.sense[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        next_s.sense[15:8] = wb_dat_i[15:8];
      end
    end

    // Edges are seen on the clamped input, so clamp release on a high pin flags even when disabled.
    for (i = 0; i < `PPOM_PINS; i = i + 1) begin
      mode = s.sense[2*i +: 2];
      case (mode)
        PPOM_SENSE_ANY: begin
          edge_set[i] = pin_sync[i] ^ s.pin_prev[i];     // RULE4
        end
        PPOM_SENSE_FALL: begin
          edge_set[i] = ~pin_sync[i] & s.pin_prev[i];
        end
        PPOM_SENSE_RISE: begin
          edge_set[i] = pin_sync[i] & ~s.pin_prev[i];    // RULE4
        end
        default: begin
          edge_set[i] = ~pin_sync[i];
        end
      endcase
    end
    next_s.pin_prev = pin_sync;

    stat_clr = '0;
    if (wr && hit_stat && wb_sel_i[0]) begin
      stat_clr = wbyte;
    end
    // A new event in the clearing cycle survives.
    next_s.int_status = (s.int_status & ~stat_clr) | edge_set;

    next_s.rdat = `PPOM_RST_WORD;
    if (req && !wb_we_i) begin
      if (hit_out) begin
        next_s.rdat[`PPOM_PINS-1:0] = s.out_data;
      end else if (hit_dir) begin
        next_s.rdat[`PPOM_PINS-1:0] = s.dir;
      end else if (hit_pin) begin
        next_s.rdat[`PPOM_PINS-1:0] = pin_sync;
      end else if (hit_ctrl) begin
        next_s.rdat[`PPOM_CTRL_PUD_BIT] = s.global_pullup_disable;
      end else if (hit_stat) begin
        next_s.rdat[`PPOM_PINS-1:0] = s.int_status;
      end else if (hit_mask) begin
        next_s.rdat[`PPOM_PINS-1:0] = s.int_mask;
      end else if (hit_sense) begin
        next_s.rdat[`PPOM_SENSE_W-1:0] = s.sense;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s.out_data   <= `PPOM_RST_BYTE;
      s.dir        <= `PPOM_RST_BYTE;
      s.int_status <= `PPOM_RST_BYTE;
      s.int_mask   <= `PPOM_RST_BYTE;
      s.sense      <= `PPOM_RST_SENSE;
      s.global_pullup_disable        <= 1'b0;
      s.pin_prev   <= `PPOM_RST_BYTE;
      s.ack        <= 1'b0;
      s.rdat       <= `PPOM_RST_WORD;
    end else begin
      s <= next_s;
    end
  end

  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.rdat;
  assign irq_o    = |(s.int_status & s.int_mask);

endmodule : ppom_port

/* ppom_port_monitor.sv */
// Checker of the port pin override mux, bound to ppom_port.
// Assumes it sees only the top ports and nrst_i as the reset.
`timescale 1ns/1ps
`include "ppom_cfg.svh"

module ppom_port_monitor (
  input wire logic                     clk_i,                // Clock
  input wire logic                     nrst_i,               // Reset
  input wire logic                     wb_cyc_i,             // Cycle
  input wire logic                     wb_stb_i,             // Strobe
  input wire logic                     wb_we_i,              // Write
  input wire logic                     wb_ack_o,             // Acknowledge
  input wire ppom_pkg::ppom_sleep_type sleep_mode_i,         // Sleep state
  input wire logic [`PPOM_PINS-1:0]    pad_in_i,             // Pad levels
  input wire logic [`PPOM_PINS-1:0]    pad_out_o,            // Drive values
  input wire logic [`PPOM_PINS-1:0]    pad_oe_o,             // Drive enables
  input wire logic [`PPOM_PINS-1:0]    pad_pullup_o,         // Pull-ups
  input wire logic [`PPOM_PINS-1:0]    pullup_override_en,   // Override
  input wire logic [`PPOM_PINS-1:0]    pullup_override_val,  // Override
  input wire logic [`PPOM_PINS-1:0]    dir_override_en,      // Override
  input wire logic [`PPOM_PINS-1:0]    dir_override_val,     // Override
  input wire logic [`PPOM_PINS-1:0]    outval_override_en,   // Override
  input wire logic [`PPOM_PINS-1:0]    outval_override_val,  // Override
  input wire logic [`PPOM_PINS-1:0]    toggle_override_en,   // Override
  input wire logic [`PPOM_PINS-1:0]    inen_override_en,     // Override
  input wire logic [`PPOM_PINS-1:0]    inen_override_val,    // Override
  input wire logic [`PPOM_PINS-1:0]    raw_digital_in,       // Raw inputs
  input wire logic [`PPOM_PINS-1:0]    analog_pad_path_o,    // Analogue
  input wire logic [`PPOM_PINS-1:0]    analog_pad_path_i,    // Analogue
  input wire logic [`PPOM_PINS-1:0]    analog_pad_path_oe_i, // Analogue
  input wire logic [`PPOM_PINS-1:0]    pad_analog_i,         // Analogue
  input wire logic [`PPOM_PINS-1:0]    pad_analog_o,         // Analogue
  input wire logic [`PPOM_PINS-1:0]    pad_analog_oe_o       // Analogue
);
  import ppom_pkg::*;
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_oe_override: assert property ((pad_oe_o & dir_override_en) == (dir_override_val & dir_override_en))
    else $error("oe override");
  a_pu_override: assert property ((pad_pullup_o & pullup_override_en) == (pullup_override_val & pullup_override_en))
    else $error("pull-up override");
  a_pu_default: assert property ((pad_pullup_o & ~pullup_override_en & ~dir_override_en & pad_oe_o) == '0)
    else $error("pull-up on output");
  a_val_override: assert property ((pad_out_o & outval_override_en) == (outval_override_val & outval_override_en & pad_oe_o))
    else $error("value override");
  a_out_gated: assert property ((pad_out_o & ~pad_oe_o) == '0)
    else $error("drive while off");
  a_raw_subset: assert property ((raw_digital_in & ~pad_in_i) == '0)
    else $error("raw above pad");
  a_inen_override: assert property ((inen_override_en & (raw_digital_in ^ (pad_in_i & inen_override_val))) == '0)
    else $error("inen override");
  a_awake_input: assert property (sleep_mode_i == PPOM_SLP_ACTIVE |-> ((raw_digital_in ^ pad_in_i) & ~inen_override_en) == '0)
    else $error("gated while awake");
  a_analog_wires: assert property (analog_pad_path_o == pad_analog_i && pad_analog_o == analog_pad_path_i
    && pad_analog_oe_o == analog_pad_path_oe_i) else $error("analogue path");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_toggle_flip: assert property (toggle_override_en[1] && pad_oe_o[1] && !outval_override_en[1]
    && !(wb_cyc_i && wb_stb_i && wb_we_i) |=> !pad_oe_o[1] || outval_override_en[1] || pad_out_o[1] != $past(pad_out_o[1]))
    else $error("no toggle");

  c_read: cover property (wb_ack_o && !wb_we_i);
  c_inen: cover property (|(raw_digital_in & inen_override_en));
  c_sleep: cover property (sleep_mode_i == PPOM_SLP_PDOWN && |raw_digital_in);
endmodule : ppom_port_monitor

bind ppom_port ppom_port_monitor u_mon (.*);

/* ppom_far_end.sv */
// Pad and peripheral model at the far side of the pin mux.
// Assumes the bench steers the external drive; the driver wins over it.
`timescale 1ns/1ps
`include "ppom_cfg.svh"

module ppom_far_end (
  input  wire logic                  clk_i,        // I/O clock
  input  wire logic [`PPOM_PINS-1:0] pad_out_i,    // Driven values
  input  wire logic [`PPOM_PINS-1:0] pad_oe_i,     // Driver enables
  input  wire logic [`PPOM_PINS-1:0] pad_pullup_i, // Pull-ups
  input  wire logic [`PPOM_PINS-1:0] ext_en_i,     // External drive on
  input  wire logic [`PPOM_PINS-1:0] ext_lvl_i,    // External level
  input  wire logic [`PPOM_PINS-1:0] raw_i,        // Raw inputs
  output logic      [`PPOM_PINS-1:0] pad_o,        // Pad levels
  output logic      [`PPOM_PINS-1:0] raw_sync_o    // Peripheral copy
);
  // ----------
  // Pad and synchroniser
  // ----------
  logic [`PPOM_PINS-1:0] last = '0;
  logic [`PPOM_PINS-1:0] meta;

  // A floating pad flips every cycle so a stale value never looks valid.
  always_comb begin
    pad_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_en_i & ext_lvl_i) | (~pad_oe_i & ~ext_en_i & (pad_pullup_i | ~last));
  end

  always_ff @(posedge clk_i) begin
    last       <= pad_o;
    meta       <= raw_i;
    raw_sync_o <= meta;
  end
endmodule : ppom_far_end

/* testbench.sv */
// Self-checking bench of ppom_port with the far side model.
// Assumes the bus answers one cycle after a request is taken.
`timescale 1ns/1ps
`include "ppom_cfg.svh"

module testbench;
  import ppom_pkg::*;
  logic clk_i, nrst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  ppom_sleep_type sleep_mode_i;
  logic [`PPOM_PINS-1:0] pad_in_i, pad_out_o, pad_oe_o, pad_pullup_o, raw_digital_in, raw_sync, ext_en, ext_lvl;
  logic [`PPOM_PINS-1:0] pullup_override_en, pullup_override_val, dir_override_en, dir_override_val;
  logic [`PPOM_PINS-1:0] outval_override_en, outval_override_val, toggle_override_en, inen_override_en;
  logic [`PPOM_PINS-1:0] inen_override_val, analog_pad_path_o, analog_pad_path_i, analog_pad_path_oe_i;
  logic [`PPOM_PINS-1:0] pad_analog_i, pad_analog_o, pad_analog_oe_o;
  int failures = 0;
  int n_checks = 0;

  ppom_port u_dut (.clk_i, .nrst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .sleep_mode_i, .pad_in_i, .pad_out_o, .pad_oe_o, .pad_pullup_o, .pullup_override_en,
    .pullup_override_val, .dir_override_en, .dir_override_val, .outval_override_en, .outval_override_val,
    .toggle_override_en, .inen_override_en, .inen_override_val, .raw_digital_in, .analog_pad_path_o,
    .analog_pad_path_i, .analog_pad_path_oe_i, .pad_analog_i, .pad_analog_o, .pad_analog_oe_o, .irq_o);

  ppom_far_end u_far (.clk_i(clk_i), .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o), .pad_pullup_i(pad_pullup_o),
    .ext_en_i(ext_en), .ext_lvl_i(ext_lvl), .raw_i(raw_digital_in), .pad_o(pad_in_i), .raw_sync_o(raw_sync));

  always #5 clk_i = ~clk_i;

  // ----------
  // Shared tasks
  // ----------
  task automatic give_verdict();
    if (failures == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
    int n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      failures++;
      give_verdict();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask : rd_chk

  task automatic settle();
    @(negedge clk_i);
  endtask : settle

  // ----------
  // Scenarios
  // ----------
  task automatic s_reset();
    logic [7:0] adrs[6] = '{8'h00, 8'h04, 8'h0c, 8'h14, 8'h18, 8'h1c};
    chk(pad_oe_o, 8'h00);
    chk(pad_pullup_o, 8'h00);
    chk(irq_o, 1'b0);
    foreach (adrs[i]) rd_chk(adrs[i], 32'h0);
  endtask : s_reset

  task automatic s_gpio();
    wr(8'h04, 32'h0f);
    wr(8'h00, 32'ha5);
    settle();
    chk(pad_oe_o, 8'h0f);
    chk(pad_out_o, 8'h05);
    chk(pad_pullup_o, 8'ha0);
    wr(8'h0c, 32'h1);
    settle();
    chk(pad_pullup_o, 8'h00);
    wr(8'h0c, 32'h0);
    wr(8'h08, 32'hff);
    rd_chk(8'h00, 32'h5a);
  endtask : s_gpio

  task automatic s_overrides();
    @(posedge clk_i);
    toggle_override_en <= 8'h02;
    @(posedge clk_i);
    toggle_override_en <= 8'h00;
    rd_chk(8'h00, 32'h58);
    @(posedge clk_i);
    pullup_override_en  <= 8'hff;
    pullup_override_val <= 8'h0f;
    dir_override_en     <= 8'hf0;
    dir_override_val    <= 8'h30;
    outval_override_en  <= 8'h0c;
    outval_override_val <= 8'h04;
    settle();
    chk(pad_pullup_o, 8'h0f);
    chk(pad_oe_o, 8'h3f);
    chk(pad_out_o, 8'h14);
    @(posedge clk_i);
    pullup_override_en <= 8'h00;
    dir_override_en    <= 8'h00;
    outval_override_en <= 8'h00;
  endtask : s_overrides

  task automatic s_sleep();
    ppom_sleep_type modes[3] = '{PPOM_SLP_PDOWN, PPOM_SLP_PSAVE, PPOM_SLP_STANDBY};
    wr(8'h04, 32'h0);
    wr(8'h18, 32'hffff);
    wr(8'h14, 32'h01);
    @(posedge clk_i);
    ext_lvl <= 8'hf3;
    settle();
    chk(raw_digital_in, 8'hf3);
    repeat (3) @(posedge clk_i);
    settle();
    chk(raw_sync, 8'hf3);
    rd_chk(8'h08, 32'hf3);
    wr(8'h10, 32'hff);
    rd_chk(8'h10, 32'h0);
    foreach (modes[i]) begin
      @(posedge clk_i);
      sleep_mode_i <= modes[i];
      settle();
      chk(raw_digital_in, 8'h01);
    end
    @(posedge clk_i);
    inen_override_en  <= 8'h02;
    inen_override_val <= 8'h02;
    settle();
    chk(raw_digital_in, 8'h03);
    @(posedge clk_i);
    inen_override_en <= 8'h00;
    sleep_mode_i     <= PPOM_SLP_ACTIVE;
    settle();
    chk(raw_digital_in, 8'hf3);
    repeat (8) @(posedge clk_i);
    rd_chk(8'h10, 32'hf2);
  endtask : s_sleep

  task automatic s_irq();
    chk(irq_o, 1'b0);
    wr(8'h14, 32'h02);
    settle();
    chk(irq_o, 1'b1);
    wr(8'h10, 32'h02);
    rd_chk(8'h10, 32'hf0);
    chk(irq_o, 1'b0);
    wr(8'h1c, 32'hff);
    rd_chk(8'h1c, 32'h0);
    @(posedge clk_i);
    inen_override_en <= 8'h10;
    settle();
    chk(raw_digital_in, 8'he3);
    @(posedge clk_i);
    inen_override_en     <= 8'h00;
    pad_analog_i         <= 8'h3c;
    analog_pad_path_i    <= 8'hc3;
    analog_pad_path_oe_i <= 8'h0f;
    settle();
    chk(analog_pad_path_o, 8'h3c);
    chk(pad_analog_o, 8'hc3);
    chk(pad_analog_oe_o, 8'h0f);
    wr(8'h18, 32'hc9ff);
    wr(8'h10, 32'hff);
    sleep_mode_i <= PPOM_SLP_IDLE;
    ext_lvl      <= 8'h03;
    repeat (6) @(posedge clk_i);
    chk(raw_digital_in, 8'h03);
    rd_chk(8'h10, 32'h70);
  endtask : s_irq

  initial begin
    clk_i = 0;
    nrst_i = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hf;
    sleep_mode_i = PPOM_SLP_ACTIVE;
    {pullup_override_en, pullup_override_val, dir_override_en, dir_override_val} = '0;
    {outval_override_en, outval_override_val, toggle_override_en, inen_override_en, inen_override_val} = '0;
    {analog_pad_path_i, analog_pad_path_oe_i, pad_analog_i, ext_lvl} = '0;
    ext_en = 8'hff;
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    s_reset();
    s_gpio();
    s_overrides();
    s_sleep();
    s_irq();
    give_verdict();
  end
endmodule : testbench
